// File: hw/fcs_top.sv
// register file, mode decode and loss reporting of the fll clock source
// Operation
// - after reset run self-clocked, about 8 MHz output and 4 MHz bus
// - range bit 6 set: high range, prescale 1; clear: low range, prescale 64
// - gain bit 7 clear configures the oscillator for low power
// - reference bit 5 requests crystal oscillator; ignored for internal reference
// - mode code 11 engages loop on external, 01 on internal reference
// - lock-loss reset enable clear: loss of lock raises an interrupt
// - clock-loss reset enable clear: loss raises interrupt; detect on when disable zero and an external scheme is selected
// - multiply code 011 gives N of 10
// - reduce code 000 divides by 1, 001 by 2
// - engaged external output is ext times P times N over R
// - engaged internal output is 243 kHz over 7 times 64 times N over R
// - control bit 0 unimplemented, reads zero
// - status one read-only except writing a one clears the matching pending interrupt flag
// - multiply codes 000 to 111 give N of 4 to 18 in steps of 2
// - self-clocked gives dco over R, bypassed external gives ext over R
`timescale 1ns/1ps
module fcs_top (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [15:0] ext_ref_khz,
  input wire logic loop_locked,
  input wire logic ext_clock_present,
  input wire logic oscillator_stable,
  output logic [1:0] clock_mode,
  output logic osc_high_range,
  output logic osc_low_power,
  output logic osc_request,
  output logic osc_stop_keep_enable,
  output logic loss_detect_active,
  output logic [6:0] loop_prescale,
  output logic [4:0] loop_mult_n,
  output logic [7:0] loop_div_r,
  output logic [7:0] reference_trim,
  output logic [31:0] generator_output_khz,
  output logic [31:0] bus_khz,
  output logic lock_loss_reset_req,
  output logic clock_loss_reset_req,
  output logic irq
);

  // ---------------- registers ----------------
  logic [7:1] src_ctrl;
  logic [7:0] loop_ctrl;
  logic [7:0] trim;
  logic [1:0] flags;
  logic [1:0] irq_mask;

  // ---------------- axi write path ----------------
  logic aw_held;
  logic [7:0] aw_addr;
  logic w_held;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_fire;
  logic wr_hit;
  logic wr_low_lane;
  logic [7:0] wr_byte;
  logic wr_src;
  logic wr_loop;
  logic wr_trim;
  logic wr_stat1;
  logic wr_mask;

  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready = ~w_held & ~s_axi_bvalid;
  assign wr_fire = aw_held & w_held & ~s_axi_bvalid;
  assign wr_low_lane = w_strb[0];
  assign wr_byte = w_data[7:0];
  assign wr_src = wr_fire & wr_low_lane & (aw_addr == fcs_pkg::ADDR_SRC_CTRL);
  assign wr_loop = wr_fire & wr_low_lane & (aw_addr == fcs_pkg::ADDR_LOOP_CTRL);
  assign wr_trim = wr_fire & wr_low_lane & (aw_addr == fcs_pkg::ADDR_TRIM);
  assign wr_stat1 = wr_fire & wr_low_lane & (aw_addr == fcs_pkg::ADDR_STATUS_ONE);
  assign wr_mask = wr_fire & wr_low_lane & (aw_addr == fcs_pkg::ADDR_IRQ_MASK);
  assign wr_hit = (aw_addr == fcs_pkg::ADDR_SRC_CTRL) | (aw_addr == fcs_pkg::ADDR_LOOP_CTRL)
                | (aw_addr == fcs_pkg::ADDR_TRIM) | (aw_addr == fcs_pkg::ADDR_STATUS_ONE)
                | (aw_addr == fcs_pkg::ADDR_STATUS_TWO) | (aw_addr == fcs_pkg::ADDR_IRQ_MASK);

  // address and data are latched independently, in either order
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
    end else if (s_axi_awvalid & s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid & s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held <= 1'b0;
    end
  end

  // status two is read-only, so writing it answers okay and changes nothing
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= fcs_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? fcs_pkg::RESP_OKAY : fcs_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ---------------- control registers ----------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      src_ctrl <= fcs_pkg::RST_SRC_CTRL[7:1];
      loop_ctrl <= fcs_pkg::RST_LOOP_CTRL;
      trim <= fcs_pkg::RST_TRIM;
      irq_mask <= fcs_pkg::RST_IRQ_MASK;
    end else begin
      if (wr_src) begin
        src_ctrl <= wr_byte[7:1];
      end
      if (wr_loop) begin
        loop_ctrl <= wr_byte;
      end
      if (wr_trim) begin
        trim <= wr_byte;
      end
      if (wr_mask) begin
        irq_mask <= wr_byte[1:0];
      end
    end
  end

  // ---------------- field decode ----------------
  fcs_pkg::fcs_mode_e mode;
  logic loop_engaged;
  logic uses_external;
  logic lol_reset_en;
  logic loc_reset_en;

  assign mode = fcs_pkg::fcs_mode_e'(src_ctrl[fcs_pkg::MODE_HI:fcs_pkg::MODE_LO]);
  assign loop_engaged = (mode == fcs_pkg::loop_engaged_internal)
                      | (mode == fcs_pkg::loop_engaged_external);
  assign uses_external = (mode == fcs_pkg::loop_bypassed_external)
                       | (mode == fcs_pkg::loop_engaged_external);
  assign lol_reset_en = loop_ctrl[fcs_pkg::LOL_RST_BIT];
  assign loc_reset_en = loop_ctrl[fcs_pkg::LOC_RST_BIT];

  assign clock_mode = mode;
  assign osc_high_range = src_ctrl[fcs_pkg::RANGE_BIT];
  assign osc_low_power = ~src_ctrl[fcs_pkg::GAIN_BIT];
  // the crystal request only matters when an external scheme is selected
  assign osc_request = src_ctrl[fcs_pkg::REFSEL_BIT] & uses_external;
  assign osc_stop_keep_enable = src_ctrl[fcs_pkg::OSC_KEEP_BIT];
  assign loss_detect_active = ~src_ctrl[fcs_pkg::LOSS_DIS_BIT] & uses_external;
  assign reference_trim = trim;

  // ---------------- frequency calculation ----------------
  fcs_cfg_if cfg ();

  assign cfg.mode = mode;
  assign cfg.range_high = src_ctrl[fcs_pkg::RANGE_BIT];
  assign cfg.multiply_factor_field = loop_ctrl[fcs_pkg::MFD_HI:fcs_pkg::MFD_LO];
  assign cfg.reduce_divide_field = loop_ctrl[fcs_pkg::RFD_HI:fcs_pkg::RFD_LO];
  assign cfg.ext_khz = ext_ref_khz;

  fcs_freq_calc u_calc (
    .cfg(cfg.calc)
  );

  assign loop_prescale = cfg.prescale;
  assign loop_mult_n = cfg.mult_n;
  assign loop_div_r = cfg.div_r;

  // registered so a factor change never glitches the reported figure
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      generator_output_khz <= fcs_pkg::DCO_SCM_KHZ;
      bus_khz <= fcs_pkg::DCO_SCM_KHZ >> 1;
    end else begin
      generator_output_khz <= cfg.out_khz;
      bus_khz <= cfg.out_khz >> 1;
    end
  end

  // ---------------- loss events ----------------
  logic [2:0] ev_raw;
  logic [2:0] ev_level;
  logic [2:0] ev_rise;
  logic locked_s;
  logic ext_ok_s;
  logic stable_s;
  logic lock_loss_ev;
  logic clock_loss_ev;
  logic lol_irq_ev;
  logic loc_irq_ev;

  // lock and clock-present inputs inverted so a loss shows as a rising edge
  assign ev_raw = {oscillator_stable, ~ext_clock_present, ~loop_locked};

  fcs_evt_sync u_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .raw(ev_raw),
    .level(ev_level),
    .rise(ev_rise)
  );

  assign locked_s = ~ev_level[0];
  assign ext_ok_s = ~ev_level[1];
  assign stable_s = ev_level[2];
  assign lock_loss_ev = ev_rise[0] & loop_engaged;
  assign clock_loss_ev = ev_rise[1] & loss_detect_active;
  assign lol_irq_ev = lock_loss_ev & ~lol_reset_en;
  assign loc_irq_ev = clock_loss_ev & ~loc_reset_en;

  // with the reset enable set a loss asks for a system reset instead
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      lock_loss_reset_req <= 1'b0;
      clock_loss_reset_req <= 1'b0;
    end else begin
      lock_loss_reset_req <= lock_loss_ev & lol_reset_en;
      clock_loss_reset_req <= clock_loss_ev & loc_reset_en;
    end
  end

  // sticky flags: a new event in the clearing cycle wins
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      flags <= 2'h0;
    end else begin
      flags[fcs_pkg::FLAG_LOCK_LOSS] <= lol_irq_ev
        | (flags[fcs_pkg::FLAG_LOCK_LOSS] & ~(wr_stat1 & wr_byte[fcs_pkg::FLAG_LOCK_LOSS]));
      flags[fcs_pkg::FLAG_CLOCK_LOSS] <= loc_irq_ev
        | (flags[fcs_pkg::FLAG_CLOCK_LOSS] & ~(wr_stat1 & wr_byte[fcs_pkg::FLAG_CLOCK_LOSS]));
    end
  end

  assign irq = |(flags & irq_mask);

  // ---------------- axi read path ----------------
  logic [7:0] stat1_view;
  logic [7:0] stat2_view;
  logic rd_hit;
  logic [7:0] rd_byte;

  assign stat1_view = {4'h0, ext_ok_s, locked_s, flags};
  assign stat2_view = {7'h00, stable_s};
  assign s_axi_arready = ~s_axi_rvalid;
  assign rd_hit = (s_axi_araddr == fcs_pkg::ADDR_SRC_CTRL)
                | (s_axi_araddr == fcs_pkg::ADDR_LOOP_CTRL)
                | (s_axi_araddr == fcs_pkg::ADDR_TRIM)
                | (s_axi_araddr == fcs_pkg::ADDR_STATUS_ONE)
                | (s_axi_araddr == fcs_pkg::ADDR_STATUS_TWO)
                | (s_axi_araddr == fcs_pkg::ADDR_IRQ_MASK);

  always_comb begin
    case (s_axi_araddr)
      fcs_pkg::ADDR_SRC_CTRL: rd_byte = {src_ctrl, 1'b0};
      fcs_pkg::ADDR_LOOP_CTRL: rd_byte = loop_ctrl;
      fcs_pkg::ADDR_TRIM: rd_byte = trim;
      fcs_pkg::ADDR_STATUS_ONE: rd_byte = stat1_view;
      fcs_pkg::ADDR_STATUS_TWO: rd_byte = stat2_view;
      fcs_pkg::ADDR_IRQ_MASK: rd_byte = {6'h00, irq_mask};
      default: rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= fcs_pkg::RESP_OKAY;
    end else if (s_axi_arvalid & s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h00_0000, rd_byte};
      s_axi_rresp <= rd_hit ? fcs_pkg::RESP_OKAY : fcs_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule : fcs_top

// File: inc/fcs_pkg.sv
// shared constants and types of the fll clock source configuration block
package fcs_pkg;

  // register byte offsets on the axi4-lite slave
  localparam logic [7:0] ADDR_SRC_CTRL = 8'h00;
  localparam logic [7:0] ADDR_LOOP_CTRL = 8'h04;
  localparam logic [7:0] ADDR_TRIM = 8'h08;
  localparam logic [7:0] ADDR_STATUS_ONE = 8'h0C;
  localparam logic [7:0] ADDR_STATUS_TWO = 8'h10;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;

  // values after reset
  localparam logic [7:0] RST_SRC_CTRL = 8'h00;
  localparam logic [7:0] RST_LOOP_CTRL = 8'h00;
  localparam logic [7:0] RST_TRIM = 8'h80;
  localparam logic [1:0] RST_IRQ_MASK = 2'h0;

  // clock_source_control field positions
  localparam int GAIN_BIT = 7;
  localparam int RANGE_BIT = 6;
  localparam int REFSEL_BIT = 5;
  localparam int MODE_HI = 4;
  localparam int MODE_LO = 3;
  localparam int OSC_KEEP_BIT = 2;
  localparam int LOSS_DIS_BIT = 1;

  // loop_factor_control field positions
  localparam int LOL_RST_BIT = 7;
  localparam int MFD_HI = 6;
  localparam int MFD_LO = 4;
  localparam int LOC_RST_BIT = 3;
  localparam int RFD_HI = 2;
  localparam int RFD_LO = 0;

  // generator_status_one / irq mask bit positions
  localparam int FLAG_LOCK_LOSS = 0;
  localparam int FLAG_CLOCK_LOSS = 1;
  localparam int STAT_LOCKED = 2;
  localparam int STAT_EXT_OK = 3;

  // frequency figures in khz
  localparam logic [31:0] DCO_SCM_KHZ = 32'h0000_1F40;
  localparam logic [31:0] IRG_KHZ = 32'h0000_00F3;
  localparam logic [31:0] IRG_DIV = 32'h0000_0007;
  localparam logic [6:0] PRESCALE_LOW = 7'h40;
  localparam logic [6:0] PRESCALE_HIGH = 7'h01;

  // axi response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    self_clocked_mode,
    loop_engaged_internal,
    loop_bypassed_external,
    loop_engaged_external
  } fcs_mode_e;

endpackage : fcs_pkg

// File: inc/fcs_cfg_if.sv
// configuration carried from the register file to the frequency calculator
`timescale 1ns/1ps
interface fcs_cfg_if;
  fcs_pkg::fcs_mode_e mode;
  logic range_high;
  logic [2:0] multiply_factor_field;
  logic [2:0] reduce_divide_field;
  logic [15:0] ext_khz;
  logic [31:0] out_khz;
  logic [4:0] mult_n;
  logic [7:0] div_r;
  logic [6:0] prescale;

  modport src (
    output mode,
    output range_high,
    output multiply_factor_field,
    output reduce_divide_field,
    output ext_khz,
    input out_khz,
    input mult_n,
    input div_r,
    input prescale
  );

  modport calc (
    input mode,
    input range_high,
    input multiply_factor_field,
    input reduce_divide_field,
    input ext_khz,
    output out_khz,
    output mult_n,
    output div_r,
    output prescale
  );
endinterface : fcs_cfg_if

// File: hw/fcs_evt_sync.sv
// two-flop synchronisers with rising-edge detection for the analog event inputs
`timescale 1ns/1ps
module fcs_evt_sync (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [2:0] raw,
  output logic [2:0] level,
  output logic [2:0] rise
);
  logic [2:0] meta;
  logic [2:0] last;

  genvar i;
  generate
    for (i = 0; i < 3; i++) begin : g_bit
      always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
          meta[i] <= 1'b0;
          level[i] <= 1'b0;
          last[i] <= 1'b0;
        end else begin
          meta[i] <= raw[i];
          level[i] <= meta[i];
          last[i] <= level[i];
        end
      end
      // edge taken from the second stage only
      assign rise[i] = level[i] & ~last[i];
    end
  endgenerate
endmodule : fcs_evt_sync

// File: hw/fcs_freq_calc.sv
// decodes loop factors and computes the generator output frequency in khz
`timescale 1ns/1ps
module fcs_freq_calc (
  fcs_cfg_if.calc cfg
);
  logic [31:0] n_wide;
  logic [31:0] p_wide;
  logic [31:0] engaged_ext;
  logic [31:0] engaged_int;
  logic [31:0] before_div;

  assign cfg.mult_n = 5'(4 + 2 * cfg.multiply_factor_field);
  assign cfg.div_r = 8'(1 << cfg.reduce_divide_field);
  assign cfg.prescale = cfg.range_high ? fcs_pkg::PRESCALE_HIGH : fcs_pkg::PRESCALE_LOW;
  assign n_wide = {27'h000_0000, cfg.mult_n};
  assign p_wide = {25'h000_0000, cfg.prescale};
  // ext * p * n
  assign engaged_ext = {16'h0000, cfg.ext_khz} * p_wide * n_wide;
  // multiply before the divide by seven to keep precision; internal prescale is fixed low
  assign engaged_int = (fcs_pkg::IRG_KHZ * {25'h000_0000, fcs_pkg::PRESCALE_LOW} * n_wide)
                       / fcs_pkg::IRG_DIV;

  always_comb begin
    case (cfg.mode)
      fcs_pkg::self_clocked_mode: before_div = fcs_pkg::DCO_SCM_KHZ;
      fcs_pkg::loop_engaged_internal: before_div = engaged_int;
      fcs_pkg::loop_bypassed_external: before_div = {16'h0000, cfg.ext_khz};
      fcs_pkg::loop_engaged_external: before_div = engaged_ext;
      default: before_div = fcs_pkg::DCO_SCM_KHZ;
    endcase
  end

  // divide by r is a shift by the field code
  assign cfg.out_khz = before_div >> cfg.reduce_divide_field;
endmodule : fcs_freq_calc

// File: dv/fcs_monitor.sv
// concurrent checks on the ports of the clock source top
`timescale 1ns/1ps
module fcs_monitor (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [15:0] ext_ref_khz,
  input wire logic [1:0] clock_mode,
  input wire logic osc_high_range,
  input wire logic [6:0] loop_prescale,
  input wire logic [4:0] loop_mult_n,
  input wire logic [7:0] loop_div_r,
  input wire logic [31:0] generator_output_khz,
  input wire logic [31:0] bus_khz,
  input wire logic lock_loss_reset_req
);
  logic [31:0] g_w, e_w, r_w, fee_w, fei_w;
  assign g_w = generator_output_khz;
  assign e_w = 32'(ext_ref_khz);
  assign r_w = 32'(loop_div_r);
  assign fee_w = e_w * 32'(loop_prescale) * 32'(loop_mult_n);
  // multiply before the divide by 7, so the truncation matches the reported figure
  assign fei_w = 32'h0000_00F3 * 32'h0000_0040 * 32'(loop_mult_n) / 32'h0000_0007;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence rd_wait;
    s_axi_rvalid && !s_axi_rready;
  endsequence
  sequence wr_wait;
    s_axi_bvalid && !s_axi_bready;
  endsequence
  range_prescale_a: assert property (loop_prescale == (osc_high_range ? 7'h01 : 7'h40))
    else $error("prescale does not follow range");
  mult_decode_a: assert property (!loop_mult_n[0] && loop_mult_n >= 5'h04 && loop_mult_n <= 5'h12)
    else $error("multiplier outside decode table");
  div_onehot_a: assert property ($onehot(loop_div_r))
    else $error("divider not a power of two");
  bus_half_a: assert property (bus_khz == {1'b0, g_w[31:1]})
    else $error("bus rate not half of output");
  scm_freq_a: assert property (clock_mode == 2'h0 |=> g_w == 32'h0000_1F40 / $past(r_w))
    else $error("self clocked output wrong");
  fbe_freq_a: assert property (clock_mode == 2'h2 |=> g_w == $past(e_w) / $past(r_w))
    else $error("bypassed output wrong");
  fee_freq_a: assert property (clock_mode == 2'h3 |=> g_w == $past(fee_w) / $past(r_w))
    else $error("engaged external output wrong");
  fei_freq_a: assert property (clock_mode == 2'h1 |=> g_w == $past(fei_w) / $past(r_w))
    else $error("engaged internal output wrong");
  read_hold_a: assert property (rd_wait |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped early");
  write_hold_a: assert property (wr_wait |=> s_axi_bvalid)
    else $error("write answer dropped early");
  lock_pulse_a: assert property ($rose(lock_loss_reset_req) |=> !lock_loss_reset_req)
    else $error("reset request longer than one cycle");
endmodule : fcs_monitor

bind fcs_top fcs_monitor u_mon (.ref_clk, .rst_n, .s_axi_bvalid, .s_axi_bready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .ext_ref_khz, .clock_mode, .osc_high_range, .loop_prescale,
  .loop_mult_n, .loop_div_r, .generator_output_khz, .bus_khz, .lock_loss_reset_req);

// File: dv/fcs_ref_model.sv
// behavioural model of the external reference and the analog status lines
`timescale 1ns/1ps
module fcs_ref_model (
  input wire logic ref_clk,
  output logic [15:0] ext_ref_khz,
  output logic loop_locked,
  output logic ext_clock_present,
  output logic oscillator_stable
);
  // a 4 MHz source, present until the bench pulls it away
  initial begin
    ext_ref_khz = 16'h0FA0;
    loop_locked = 1'b1;
    ext_clock_present = 1'b1;
    oscillator_stable = 1'b1;
  end
  task automatic set_lock(input logic v);
    @(posedge ref_clk);
    loop_locked <= v;
  endtask : set_lock
  task automatic set_clock(input logic v);
    @(posedge ref_clk);
    ext_clock_present <= v;
  endtask : set_clock
  task automatic set_stable(input logic v);
    @(posedge ref_clk);
    oscillator_stable <= v;
  endtask : set_stable
  task automatic set_ext(input logic [15:0] v);
    @(posedge ref_clk);
    ext_ref_khz <= v;
  endtask : set_ext
endmodule : fcs_ref_model

// File: dv/fcs_top_test.sv
// self-checking bench for the fll clock source block
`timescale 1ns/1ps
module fcs_top_test;
  localparam logic [31:0] ONE = 32'h0000_0001;
  localparam logic [31:0] ZERO = 32'h0000_0000;
  logic ref_clk, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, irq;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr, loop_div_r, reference_trim;
  logic [31:0] s_axi_wdata, s_axi_rdata, generator_output_khz, bus_khz;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, clock_mode;
  logic [15:0] ext_ref_khz;
  logic loop_locked, ext_clock_present, oscillator_stable, osc_high_range, osc_low_power;
  logic osc_request, osc_stop_keep_enable, loss_detect_active, lock_loss_reset_req;
  logic clock_loss_reset_req;
  logic [6:0] loop_prescale;
  logic [4:0] loop_mult_n;
  int fails, tests_run, cycles;
  fcs_top DUT (.ref_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .ext_ref_khz, .loop_locked, .ext_clock_present, .oscillator_stable,
    .clock_mode, .osc_high_range, .osc_low_power, .osc_request, .osc_stop_keep_enable,
    .loss_detect_active, .loop_prescale, .loop_mult_n, .loop_div_r, .reference_trim,
    .generator_output_khz, .bus_khz, .lock_loss_reset_req, .clock_loss_reset_req, .irq);
  fcs_ref_model u_ref (.ref_clk, .ext_ref_khz, .loop_locked, .ext_clock_present,
    .oscillator_stable);
  always #5 ref_clk = ~ref_clk;
  // the whole run needs well under two thousand cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles > 8000) begin
      fails++;
      end_sim();
    end
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // one transfer; for a read, d is the expected data
  task automatic bus(input logic wr_op, input string what, input logic [7:0] a,
    input logic [31:0] d, input logic [1:0] er, input logic [3:0] st);
    logic ta, tw, tr, fin;
    fin = 1'b0;
    @(posedge ref_clk);
    if (wr_op) begin
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wstrb <= st;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
    end else begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
    end
    while (!fin) begin
      @(negedge ref_clk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tr = s_axi_arvalid && s_axi_arready;
      fin = wr_op ? s_axi_bvalid : s_axi_rvalid;
      if (fin) chk("resp", 32'(er), wr_op ? 32'(s_axi_bresp) : 32'(s_axi_rresp));
      if (fin && !wr_op) chk(what, d, s_axi_rdata);
      @(posedge ref_clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tr) s_axi_arvalid <= 1'b0;
      if (fin) s_axi_bready <= 1'b0;
      if (fin) s_axi_rready <= 1'b0;
    end
    repeat (2) @(negedge ref_clk);
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0,
    input logic [3:0] st = 4'hF);
    bus(1'b1, "", a, d, er, st);
  endtask : wr
  task automatic rd(input string w, input logic [7:0] a, input logic [31:0] e,
    input logic [1:0] er = 2'h0);
    bus(1'b0, w, a, e, er, 4'hF);
  endtask : rd
  // events pass two sync flops and an edge detector, so eight cycles is ample
  task automatic wait_bit(input string what, input logic [1:0] sel, input logic v);
    logic s;
    s = 1'bx;
    for (int k = 0; k < 8; k++) begin
      @(negedge ref_clk);
      s = sel[1] ? clock_loss_reset_req : (sel[0] ? lock_loss_reset_req : irq);
      if (s === v) break;
    end
    chk(what, 32'(v), 32'(s));
  endtask : wait_bit
  task automatic t_reset;
    @(negedge ref_clk);
    chk("out_khz", 32'h0000_1F40, generator_output_khz);
    chk("bus_khz", 32'h0000_0FA0, bus_khz);
    chk("mode", ZERO, 32'(clock_mode));
    rd("trim", fcs_pkg::ADDR_TRIM, 32'h0000_0080);
    rd("mask", fcs_pkg::ADDR_IRQ_MASK, ZERO);
    wr(fcs_pkg::ADDR_SRC_CTRL, 32'h0000_00FF);
    chk("keep", ONE, 32'(osc_stop_keep_enable));
    chk("lossdet", ZERO, 32'(loss_detect_active));
    rd("src", fcs_pkg::ADDR_SRC_CTRL, 32'h0000_00FE);
    rd("stat2", fcs_pkg::ADDR_STATUS_TWO, ONE);
    u_ref.set_stable(1'b0);
    repeat (2) @(negedge ref_clk);
    rd("stat2", fcs_pkg::ADDR_STATUS_TWO, ZERO);
    u_ref.set_stable(1'b1);
    wr(fcs_pkg::ADDR_STATUS_ONE, 32'h0000_00FF);
    rd("stat1", fcs_pkg::ADDR_STATUS_ONE, 32'h0000_000C);
    wr(8'h20, ONE, fcs_pkg::RESP_SLVERR);
    rd("hole", 8'h20, ZERO, fcs_pkg::RESP_SLVERR);
  endtask : t_reset
  task automatic t_fee;
    wr(fcs_pkg::ADDR_SRC_CTRL, 32'h0000_0078);
    wr(fcs_pkg::ADDR_LOOP_CTRL, 32'h0000_0030);
    chk("out_khz", 32'h0000_9C40, generator_output_khz);
    chk("bus_khz", 32'h0000_4E20, bus_khz);
    chk("mode", 32'h0000_0003, 32'(clock_mode));
    chk("mult", 32'h0000_000A, 32'(loop_mult_n));
    chk("presc", ONE, 32'(loop_prescale));
    chk("range", ONE, 32'(osc_high_range));
    chk("lowpwr", ONE, 32'(osc_low_power));
    chk("oscreq", ONE, 32'(osc_request));
    chk("lossdet", ONE, 32'(loss_detect_active));
  endtask : t_fee
  task automatic t_fei;
    wr(fcs_pkg::ADDR_SRC_CTRL, 32'h0000_0028);
    wr(fcs_pkg::ADDR_LOOP_CTRL, 32'h0000_0031);
    chk("out_khz", 32'h0000_2B64, generator_output_khz);
    chk("presc", 32'h0000_0040, 32'(loop_prescale));
    chk("oscreq", ZERO, 32'(osc_request));
    chk("mode", ONE, 32'(clock_mode));
    wr(fcs_pkg::ADDR_LOOP_CTRL, 32'h0000_0032);
    wr(fcs_pkg::ADDR_TRIM, 32'h0000_0090);
    chk("trim", 32'h0000_0090, 32'(reference_trim));
    wr(fcs_pkg::ADDR_TRIM, 32'h0000_0011, fcs_pkg::RESP_OKAY, 4'hE);
    chk("trim", 32'h0000_0090, 32'(reference_trim));
    chk("out_khz", 32'h0000_15B2, generator_output_khz);
    wr(fcs_pkg::ADDR_LOOP_CTRL, 32'h0000_0031);
    chk("out_khz", 32'h0000_2B64, generator_output_khz);
  endtask : t_fei
  task automatic t_decode;
    wr(fcs_pkg::ADDR_SRC_CTRL, 32'h0000_0010);
    chk("mode", 32'h0000_0002, 32'(clock_mode));
    u_ref.set_ext(16'h0BB8);
    repeat (2) @(negedge ref_clk);
    chk("out_khz", 32'h0000_05DC, generator_output_khz);
    u_ref.set_ext(16'h0FA0);
    for (int i = 0; i < 8; i++) begin
      wr(fcs_pkg::ADDR_LOOP_CTRL, 32'(i * 17));
      chk("mult", 32'(4 + 2 * i), 32'(loop_mult_n));
      chk("div", ONE << i, 32'(loop_div_r));
      chk("out_khz", 32'h0000_0FA0 >> i, generator_output_khz);
    end
    wr(fcs_pkg::ADDR_SRC_CTRL, ZERO);
    chk("out_khz", 32'h0000_003E, generator_output_khz);
  endtask : t_decode
  task automatic t_irq;
    wr(fcs_pkg::ADDR_SRC_CTRL, 32'h0000_0078);
    wr(fcs_pkg::ADDR_LOOP_CTRL, 32'h0000_0030);
    wr(fcs_pkg::ADDR_IRQ_MASK, 32'h0000_0003);
    u_ref.set_lock(1'b0);
    wait_bit("irq", 2'h0, 1'b1);
    rd("stat1", fcs_pkg::ADDR_STATUS_ONE, 32'h0000_0009);
    wr(fcs_pkg::ADDR_STATUS_ONE, ONE);
    chk("irq", ZERO, 32'(irq));
    u_ref.set_lock(1'b1);
    wr(fcs_pkg::ADDR_IRQ_MASK, ONE);
    u_ref.set_clock(1'b0);
    repeat (4) @(negedge ref_clk);
    chk("irq", ZERO, 32'(irq));
    rd("stat1", fcs_pkg::ADDR_STATUS_ONE, 32'h0000_0006);
    wr(fcs_pkg::ADDR_IRQ_MASK, 32'h0000_0003);
    chk("irq", ONE, 32'(irq));
    wr(fcs_pkg::ADDR_STATUS_ONE, 32'h0000_0002);
    chk("irq", ZERO, 32'(irq));
    u_ref.set_clock(1'b1);
    wr(fcs_pkg::ADDR_LOOP_CTRL, 32'h0000_00B0);
    u_ref.set_lock(1'b0);
    wait_bit("lol_req", 2'h1, 1'b1);
    rd("stat1", fcs_pkg::ADDR_STATUS_ONE, 32'h0000_0008);
    u_ref.set_lock(1'b1);
    wr(fcs_pkg::ADDR_LOOP_CTRL, 32'h0000_00B8);
    u_ref.set_clock(1'b0);
    wait_bit("loc_req", 2'h2, 1'b1);
    rd("stat1", fcs_pkg::ADDR_STATUS_ONE, 32'h0000_0004);
    u_ref.set_clock(1'b1);
  endtask : t_irq
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_sim
  initial begin
    ref_clk = 1'b0;
    rst_n = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_reset();
    t_fee();
    t_fei();
    t_decode();
    t_irq();
    end_sim();
  end
endmodule : fcs_top_test
